/* File: logic/nic_command_and_bus_config_regs.sv */
// command and bus cycle configuration registers behind an apb slave
`timescale 1ns/1ps
module nic_command_and_bus_config_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nic_regs_pkg::ADDR_W-1:0] paddr,
    input wire logic [nic_regs_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [nic_regs_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mac_rx_busy,
    input wire logic tx_status_written,
    input wire logic tx_eol_found,
    input wire nic_regs_pkg::tx_abort_t tx_abort,
    output nic_regs_pkg::cfg_fields_t cfg,
    output nic_regs_pkg::engine_ctl_t engine,
    output logic tx_go,
    output logic tx_fetch_start,
    output logic tx_halted
);
    import nic_regs_pkg::*;

    // bus decode
    logic setup;
    logic access;
    logic [9:0] idx;
    logic mapped;
    logic wr_cmd;
    logic wr_cfg;
    logic [15:0] cfg_word;

    // bus answer registers
    logic pready_d;
    logic pslverr_d;
    logic [DATA_W-1:0] prdata_d;
    logic [DATA_W-1:0] rd_value;

    // command bits
    logic sw_rst_q;
    logic sw_rst_d;
    logic rx_stop_q;
    logic rx_stop_d;
    rx_state_t rx_state_q;
    rx_state_t rx_state_d;
    logic cmd_live;
    logic wr_rx_go;
    logic wr_rx_stop;
    logic wr_rx_stop_zero;
    logic rx_go_bit;

    // engine controls
    engine_ctl_t engine_d;

    // transmit command
    logic tx_go_set;
    logic tx_halt_set;
    logic tx_halt_bit;
    logic tx_sm_rst;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: a setup cycle is answered in the following access cycle
    always_comb begin
        setup = psel && !penable;
        access = psel && penable && pready;
        idx = paddr[ADDR_W-1:2];
        mapped = (paddr[1:0] == 2'b00) && (idx == CMD_IDX || idx == CFG_IDX || idx == STAT_IDX);
    end

    // command writes only use the low byte lane, where all live bits sit
    assign wr_cmd = access && pwrite && mapped && idx == CMD_IDX && pstrb[0];
    // configuration is writable only while software reset holds the machines
    assign wr_cfg = access && pwrite && mapped && idx == CFG_IDX && sw_rst_q;

    // other command bits are ignored until software reset has been released
    assign cmd_live = wr_cmd && !sw_rst_q;
    assign wr_rx_go = cmd_live && pwdata[CMD_RX_GO_BIT];
    assign wr_rx_stop = cmd_live && pwdata[CMD_RX_STOP_BIT];
    assign wr_rx_stop_zero = cmd_live && !pwdata[CMD_RX_STOP_BIT];
    assign tx_go_set = cmd_live && pwdata[CMD_TX_GO_BIT]; // zero writes fall through
    assign tx_halt_set = cmd_live && pwdata[CMD_TX_HALT_BIT];
    assign tx_sm_rst = sys_rst || sw_rst_q;

    ////////////////////////////////////////////////////////////////////////////
    // software reset bit: set by hardware reset, written either way by software
    always_comb begin
        sw_rst_d = sw_rst_q;
        if (wr_cmd) begin
            sw_rst_d = pwdata[CMD_SW_RST_BIT];
        end
        if (sys_rst) begin
            sw_rst_d = CMD_SW_RST_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        sw_rst_q <= sw_rst_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive enable and disable; a stop request outranks a go in the same write, except in RX_WAIT_OFF where the go wins
    always_comb begin
        rx_state_d = rx_state_q;
        rx_stop_d = rx_stop_q;
        unique case (rx_state_q)
            RX_OFF: begin
                if (wr_rx_stop) begin
                    rx_stop_d = 1'b1;
                end else if (wr_rx_go) begin
                    if (mac_rx_busy) begin
                        rx_state_d = RX_WAIT_ON; // never start inside a frame
                        rx_stop_d = 1'b1;
                    end else begin
                        rx_state_d = RX_ON;
                        rx_stop_d = 1'b0;
                    end
                end
            end
            RX_WAIT_ON: begin
                if (wr_rx_stop) begin
                    rx_state_d = RX_OFF;
                    rx_stop_d = 1'b1;
                end else if (!mac_rx_busy) begin
                    rx_state_d = RX_ON; // line idle, both bits resolve
                    rx_stop_d = 1'b0;
                end else if (wr_rx_stop_zero) begin
                    rx_stop_d = 1'b0;
                end
            end
            RX_ON: begin
                if (wr_rx_stop) begin
                    rx_stop_d = 1'b1;
                    if (mac_rx_busy) begin
                        rx_state_d = RX_WAIT_OFF; // finish the current packet
                    end else begin
                        rx_state_d = RX_OFF;
                    end
                end
            end
            RX_WAIT_OFF: begin
                if (wr_rx_go || wr_rx_stop_zero) begin
                    rx_state_d = RX_ON; // stop cleared while both set, disable withdrawn
                    rx_stop_d = 1'b0;
                end else if (!mac_rx_busy) begin
                    rx_state_d = RX_OFF; // packet done, go clears itself
                end
            end
        endcase
        if (sw_rst_q) begin
            rx_state_d = RX_OFF;
            rx_stop_d = 1'b1;
        end
        if (sys_rst) begin
            rx_state_d = RX_OFF;
            rx_stop_d = CMD_RX_STOP_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        rx_state_q <= rx_state_d;
        rx_stop_q <= rx_stop_d;
    end

    assign rx_go_bit = (rx_state_q != RX_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // controls handed to the receive engine, crc generator and tally block
    always_comb begin
        engine_d.state_machine_reset = sw_rst_d || sys_rst;
        engine_d.crc_gen_en = !sw_rst_d && !sys_rst;
        // tallies only follow software and hardware reset, never the receive stop bit
        engine_d.tally_count_en = !sw_rst_d && !sys_rst;
        engine_d.rx_buffering = (rx_state_d == RX_ON) || (rx_state_d == RX_WAIT_OFF);
        engine_d.rx_fifo_en = engine_d.rx_buffering;
    end

    // registered from the next-state values so the outputs come straight from flops, in step with the state
    always_ff @(posedge clk_sys) begin
        engine <= engine_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit go and halt sequencing
    transmit_cmd_ctrl u_tx_cmd (
        .clk_sys(clk_sys),
        .sm_rst(tx_sm_rst),
        .go_set(tx_go_set), // software keeps filter load apart from this
        .halt_set(tx_halt_set),
        .status_written(tx_status_written),
        .eol_found(tx_eol_found),
        .abort_flags(tx_abort),
        .go_q(tx_go),
        .halt_q(tx_halt_bit),
        .fetch_start_q(tx_fetch_start),
        .halted_q(tx_halted)
    );

    // bus cycle configuration word
    config_word_reg u_cfg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_en(wr_cfg),
        .wdata(pwdata[15:0]),
        .be(pstrb[1:0]),
        .cfg_q(cfg)
    );

    assign cfg_word = 16'(cfg);

    ////////////////////////////////////////////////////////////////////////////
    // read mux; upper sixteen bits and unused bits read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (idx)
            CMD_IDX: begin
                rd_value[CMD_TX_HALT_BIT] = tx_halt_bit;
                rd_value[CMD_TX_GO_BIT] = tx_go;
                rd_value[CMD_RX_STOP_BIT] = rx_stop_q;
                rd_value[CMD_RX_GO_BIT] = rx_go_bit;
                rd_value[CMD_SW_RST_BIT] = sw_rst_q;
            end
            CFG_IDX: begin
                rd_value[15:0] = cfg_word; // readable whether or not software reset is set
            end
            STAT_IDX: begin
                rd_value[STAT_RX_BUF_BIT] = engine.rx_buffering;
                rd_value[STAT_RX_BUSY_BIT] = mac_rx_busy;
                rd_value[STAT_RX_WAIT_BIT] = (rx_state_q == RX_WAIT_ON) || (rx_state_q == RX_WAIT_OFF);
                rd_value[STAT_TX_ACT_BIT] = tx_go;
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
        if (!mapped) begin
            rd_value = 32'h0000_0000;
        end
    end

    // answer registers: read data is captured at the setup edge
    always_comb begin
        pready_d = setup;
        pslverr_d = setup && !mapped;
        prdata_d = prdata;
        if (setup) begin
            prdata_d = pwrite ? 32'h0000_0000 : rd_value;
        end
        if (sys_rst) begin
            pready_d = 1'b0;
            pslverr_d = 1'b0;
            prdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        pready <= pready_d;
        pslverr <= pslverr_d;
        prdata <= prdata_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    rx_go_start_a: assert property (rx_state_q == RX_OFF && wr_rx_go && !wr_rx_stop && !mac_rx_busy && !sw_rst_q
        |=> rx_go_bit && !rx_stop_q ##1 engine.rx_buffering)
        else $error("receive go did not start buffering");
    rx_no_midframe_a: assert property ($rose(engine.rx_buffering) |-> !$past(mac_rx_busy))
        else $error("buffering started inside a frame");
    rx_stop_waits_a: assert property (rx_state_q == RX_ON && wr_rx_stop && mac_rx_busy && !sw_rst_q
        |=> rx_go_bit && rx_stop_q && engine.rx_buffering)
        else $error("receive stop cut a packet short");
    tally_free_a: assert property ($changed(rx_stop_q) && !$changed(sw_rst_q) |=> $stable(engine.tally_count_en))
        else $error("tally enable followed receive stop");
    stop_zero_clears_a: assert property (rx_go_bit && rx_stop_q && wr_rx_stop_zero && mac_rx_busy
        |=> !rx_stop_q)
        else $error("zero write did not clear receive stop");
    cfg_locked_a: assert property (access && pwrite && idx == CFG_IDX && !sw_rst_q |=> $stable(cfg_word))
        else $error("configuration changed outside software reset");
    // engine controls follow the reset bit in the same cycle, the transmit flop one cycle later
    sw_rst_halts_a: assert property (sw_rst_q |-> !engine.tally_count_en && !engine.crc_gen_en ##1 !tx_go)
        else $error("software reset left engines running");
    apb_answer_a: assert property (setup |=> pready ##1 !pready) // one-cycle answer
        else $error("apb answer not given in the access cycle");
endmodule

/* File: logic/nic_regs_pkg.sv */
// constants, field layouts and types shared by the command and bus configuration registers
// Overview of operation
// - receive go starts buffering, clears receive stop
// - mid-packet enable waits for idle line
// - receive stop waits for current packet end
// - tally counters ignore receive stop bit
// - zero write clears stop when both set
// - transmit go fetches descriptors then transmits
// - transmit go clears on list end, halt, abort
// - abort on any transmit control error flag
// - halt stops after frame, pointer stays put
// - halt examined only after status write-back
// - configuration register at index one, sixteen bits
// - hardware reset clears bits fifteen, thirteen only
// - configuration field layout as defined
// - command bits self-clear when command completes
// - writing zero to command bit does nothing; a zero written to the software reset bit clears it
// - configuration writes outside reset are ignored
// - software reset halts machines, crc, tallies
package nic_regs_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [9:0] CMD_IDX = 10'h000;
    localparam logic [9:0] CFG_IDX = 10'h001;
    localparam logic [9:0] STAT_IDX = 10'h002;

    // command register bit positions
    localparam int unsigned CMD_TX_HALT_BIT = 0;
    localparam int unsigned CMD_TX_GO_BIT = 1;
    localparam int unsigned CMD_RX_STOP_BIT = 2;
    localparam int unsigned CMD_RX_GO_BIT = 3;
    localparam int unsigned CMD_SW_RST_BIT = 7;

    // status register bit positions
    localparam int unsigned STAT_RX_BUF_BIT = 0;
    localparam int unsigned STAT_RX_BUSY_BIT = 1;
    localparam int unsigned STAT_RX_WAIT_BIT = 2;
    localparam int unsigned STAT_TX_ACT_BIT = 3;

    // configuration register masks
    localparam logic [15:0] CFG_WRITE_MASK = 16'hbfff;
    localparam logic [15:0] CFG_HW_RST_CLEAR = 16'ha000;

    // reset values of command bits
    localparam logic CMD_SW_RST_RESET = 1'b1;
    localparam logic CMD_RX_STOP_RESET = 1'b1;

    typedef struct packed {
        logic extended_bus_select;
        logic zero14;
        logic latched_retry;
        logic [1:0] programmable_output_bits;
        logic synchronous_bus_select;
        logic [1:0] user_pin_bits;
        logic [1:0] wait_state_count;
        logic data_width_select;
        logic dma_block_mode;
        logic [1:0] receive_fifo_threshold;
        logic [1:0] transmit_fifo_threshold;
    } cfg_fields_t;

    typedef struct packed {
        logic excessive_collisions;
        logic excessive_deferral;
        logic fifo_underrun;
        logic byte_count_mismatch;
    } tx_abort_t;

    typedef struct packed {
        logic state_machine_reset;
        logic crc_gen_en;
        logic tally_count_en;
        logic rx_buffering;
        logic rx_fifo_en;
    } engine_ctl_t;

    typedef enum logic [1:0] {RX_OFF, RX_WAIT_ON, RX_ON, RX_WAIT_OFF} rx_state_t;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

endpackage

/* File: logic/config_word_reg.sv */
// storage of the bus cycle configuration word
`timescale 1ns/1ps
module config_word_reg (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [15:0] wdata,
    input wire logic [1:0] be,
    output nic_regs_pkg::cfg_fields_t cfg_q
);
    import nic_regs_pkg::*;

    logic [15:0] word_q;
    logic [15:0] word_d;

    default clocking cb @(posedge clk_sys); endclocking

    ////////////////////////////////////////////////////////////////////////////
    // next value: only the two reset bits are touched by hardware reset
    always_comb begin
        word_d = word_q;
        if (sys_rst) begin
            word_d = word_q & ~CFG_HW_RST_CLEAR;
        end else if (wr_en) begin
            if (be[0]) begin
                word_d[7:0] = wdata[7:0];
            end
            if (be[1]) begin
                word_d[15:8] = wdata[15:8];
            end
            word_d = word_d & CFG_WRITE_MASK;
        end
    end

    // other bits keep their prior value across reset, so they are unknown until programmed
    always_ff @(posedge clk_sys) begin
        word_q <= word_d;
    end

    assign cfg_q = cfg_fields_t'(word_q);

    ////////////////////////////////////////////////////////////////////////////
    hw_reset_clear_a: assert property (sys_rst |=> !word_q[15] && !word_q[13])
        else $error("hardware reset left bit 15 or 13 set");
    write_keeps_zero_a: assert property (disable iff (sys_rst) wr_en && be[1] |=> !word_q[14])
        else $error("reserved bit 14 took a written one");
endmodule

/* File: logic/transmit_cmd_ctrl.sv */
// transmit go and halt command sequencing
`timescale 1ns/1ps
module transmit_cmd_ctrl (
    input wire logic clk_sys,
    input wire logic sm_rst,
    input wire logic go_set,
    input wire logic halt_set,
    input wire logic status_written,
    input wire logic eol_found,
    input wire nic_regs_pkg::tx_abort_t abort_flags,
    output logic go_q,
    output logic halt_q,
    output logic fetch_start_q,
    output logic halted_q
);
    import nic_regs_pkg::*;

    tx_state_t state_q;
    tx_state_t state_d;
    logic go_d;
    logic halt_d;
    logic fetch_start_d;
    logic halted_d;
    logic abort;
    logic halt_now;
    logic stop;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sm_rst);

    ////////////////////////////////////////////////////////////////////////////
    // any error flag of the transmit control register aborts the queue
    assign abort = |abort_flags;
    // halt is looked at only once the descriptor status word is back in memory
    assign halt_now = status_written && (halt_q || halt_set);
    assign stop = abort || eol_found || halt_now;

    always_comb begin
        state_d = state_q;
        go_d = go_q;
        halt_d = halt_q;
        fetch_start_d = 1'b0;
        halted_d = 1'b0;
        unique case (state_q)
            TX_IDLE: begin
                halt_d = 1'b0; // nothing to halt, command completes at once
                if (go_set) begin
                    state_d = TX_SEND;
                    go_d = 1'b1;
                    fetch_start_d = 1'b1;
                end
            end
            TX_SEND: begin
                if (halt_set) begin
                    halt_d = 1'b1;
                end
                if (stop) begin
                    state_d = TX_IDLE;
                    go_d = 1'b0;
                    halt_d = 1'b0;
                    halted_d = halt_now && !abort && !eol_found; // engine keeps its descriptor pointer
                    if (go_set) begin
                        // a fresh go in the stop cycle wins over the clear
                        state_d = TX_SEND;
                        go_d = 1'b1;
                        fetch_start_d = 1'b1;
                    end
                end
            end
        endcase
        if (sm_rst) begin
            state_d = TX_IDLE;
            go_d = 1'b0;
            halt_d = 1'b0;
            fetch_start_d = 1'b0;
            halted_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        state_q <= state_d;
        go_q <= go_d;
        halt_q <= halt_d;
        fetch_start_q <= fetch_start_d;
        halted_q <= halted_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    go_fetches_a: assert property (state_q == TX_IDLE && go_set |=> fetch_start_q && go_q)
        else $error("transmit go did not start a descriptor fetch");
    abort_clears_a: assert property (go_q && abort && !go_set |=> !go_q && !halted_q)
        else $error("transmit abort did not clear transmit go");
    halt_waits_status_a: assert property (go_q && halt_q && !status_written && !abort && !eol_found |=> go_q)
        else $error("halt took effect before status write-back");
    halt_effect_a: assert property (go_q && halt_q && status_written && !abort && !eol_found && !go_set
        |=> !go_q && !halt_q && halted_q)
        else $error("halt did not stop transmit after status write-back");
endmodule

/* File: testbench/engine_model.sv */
// behavioural transmit and receive engines facing the command logic
`timescale 1ns/1ps
module engine_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tx_go,
    input wire logic rx_busy_in,
    input wire logic [1:0] mode,
    input wire logic [1:0] abort_sel,
    input wire logic [3:0] gap,
    output logic mac_rx_busy,
    output logic tx_status_written,
    output logic tx_eol_found,
    output nic_regs_pkg::tx_abort_t tx_abort
);
    import nic_regs_pkg::*;
    logic [3:0] cnt;
    //////////////////////////////////////////////////
    // line activity comes straight from the bench
    assign mac_rx_busy = rx_busy_in;
    // a status write-back every gap plus one cycles; a large gap models a slow engine
    always @(posedge clk_sys) begin
        if (sys_rst || !tx_go) begin
            cnt <= 4'h0;
        end else begin
            cnt <= (cnt == gap) ? 4'h0 : cnt + 4'h1;
        end
        tx_status_written <= tx_go && !sys_rst && cnt == gap;
        tx_eol_found <= tx_go && !sys_rst && cnt == gap && mode == 2'h1;
        // one abort flag at a time, only while a transmit is running
        tx_abort <= (tx_go && mode == 2'h2) ? tx_abort_t'(4'h8 >> abort_sel) : tx_abort_t'(4'h0);
    end
endmodule

/* File: testbench/nic_command_and_bus_config_regs_tb.sv */
// self-checking bench for the command and bus configuration registers
`timescale 1ns/1ps
module nic_command_and_bus_config_regs_tb;
    import nic_regs_pkg::*;
    logic clk_sys, sys_rst, psel, penable, pwrite, rx_busy, err;
    logic pready, pslverr, st_wr, end_of_list_flag, mac_busy, tx_go, fetch, halted;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb, gap;
    logic [1:0] mode, asel;
    tx_abort_t abrt;
    cfg_fields_t cfg;
    engine_ctl_t eng;
    int error_cnt = 0;
    int checked = 0;
    int fetches = 0;
    int halts = 0;
    //////////////////////////////////////////////////
    nic_command_and_bus_config_regs DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac_rx_busy(mac_busy),
        .tx_status_written(st_wr), .tx_eol_found(end_of_list_flag), .tx_abort(abrt), .cfg(cfg), .engine(eng),
        .tx_go(tx_go), .tx_fetch_start(fetch), .tx_halted(halted));
    engine_model PARTNER (.clk_sys(clk_sys), .sys_rst(sys_rst), .tx_go(tx_go), .rx_busy_in(rx_busy),
        .mode(mode), .abort_sel(asel), .gap(gap), .mac_rx_busy(mac_busy), .tx_status_written(st_wr),
        .tx_eol_found(end_of_list_flag), .tx_abort(abrt));
    //////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // count the one-cycle transmit pulses, they are too short to poll from tasks
    always @(posedge clk_sys) begin
        if (fetch === 1'b1) fetches++;
        if (halted === 1'b1) halts++;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk(rd, exp);
    endtask
    // bounded wait for the transmit command to end; the first edge lets the go write show
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (tx_go !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        // one more edge so the pulse counters have seen the last pulse
        @(posedge clk_sys);
        if (n >= 300) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    //////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h3;
        rx_busy = 1'b0;
        mode = 2'h0;
        asel = 2'h0;
        gap = 4'h3;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk({eng, cfg.extended_bus_select, cfg.latched_retry}, 32'h0000_0040);
        rdc(CMD_IDX, 32'h0000_0084);
        // configuration first, while still in software reset
        apb(1'b1, CFG_IDX, 16'hffff);
        rdc(CFG_IDX, 32'h0000_bfff);
        chk(cfg, 32'h0000_bfff);
        apb(1'b1, CMD_IDX, 16'h0000);
        rdc(CMD_IDX, 32'h0000_0004);
        apb(1'b1, CFG_IDX, 16'h0000);
        rdc(CFG_IDX, 32'h0000_bfff);
        chk({eng.state_machine_reset, eng.tally_count_en}, 32'h0000_0001);
        $display("test configuration done");
        apb(1'b1, CMD_IDX, 16'h0008);
        rdc(CMD_IDX, 32'h0000_0008);
        chk(eng, 32'h0000_000f);
        rx_busy <= 1'b1;
        apb(1'b1, CMD_IDX, 16'h0004);
        rdc(CMD_IDX, 32'h0000_000c);
        chk(eng.rx_buffering, 32'h0000_0001);
        apb(1'b1, CMD_IDX, 16'h0000);
        rdc(CMD_IDX, 32'h0000_0008);
        apb(1'b1, CMD_IDX, 16'h0004);
        rx_busy <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdc(CMD_IDX, 32'h0000_0004);
        chk({eng.rx_buffering, eng.tally_count_en}, 32'h0000_0001);
        rx_busy <= 1'b1;
        apb(1'b1, CMD_IDX, 16'h0008);
        rdc(CMD_IDX, 32'h0000_000c);
        chk(eng.rx_buffering, 32'h0000_0000);
        rx_busy <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdc(CMD_IDX, 32'h0000_0008);
        chk(eng.rx_buffering, 32'h0000_0001);
        $display("test receive done");
        // never combined with an address filter load
        mode <= 2'h1;
        apb(1'b1, CMD_IDX, 16'h0002);
        wait_idle();
        chk(fetches, 32'h0000_0001);
        rdc(CMD_IDX, 32'h0000_0008);
        for (int i = 0; i < 4; i++) begin
            mode <= 2'h2;
            asel <= 2'(i);
            apb(1'b1, CMD_IDX, 16'h0002);
            wait_idle();
            chk(fetches, 32'(2 + i));
        end
        // slow engine so the halt lands mid-frame
        mode <= 2'h0;
        gap <= 4'hf;
        apb(1'b1, CMD_IDX, 16'h0002);
        apb(1'b1, CMD_IDX, 16'h0001);
        wait_idle();
        chk(halts, 32'h0000_0001);
        rdc(CMD_IDX, 32'h0000_0008);
        apb(1'b1, CMD_IDX, 16'h0001);
        rdc(CMD_IDX, 32'h0000_0008);
        $display("test transmit done");
        apb(1'b0, 10'h003, 16'h0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, CMD_IDX, 16'h0080);
        rdc(CFG_IDX, 32'h0000_bfff);
        rdc(CMD_IDX, 32'h0000_0084);
        chk(eng, 32'h0000_0010);
        apb(1'b1, CFG_IDX, 16'hb5a5);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk(cfg, 32'h0000_15a5);
        $display("test resets done");
        print_verdict();
    end
endmodule
